//--- shared/vsrb_pkg.sv
// vertical sequence register bank: shared constants, field layouts and carriers
// assumes one 50 MHz clock domain; serial pins arrive asynchronous to it
package vsrb_pkg;

	// ==========================================================
	// word layout
	localparam int WORD_W = 32;
	localparam int WORD_COUNT = 8;
	localparam int WORD_AW = 3;
	localparam int IDX_W = 4;
	localparam int BIT_CNT_W = 5;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h1F;
	localparam logic [IDX_W-1:0] IDX_SATURATE = 4'hF;

	// ==========================================================
	// header word fields
	localparam int HDR_ADDR_MSB = 31;
	localparam int HDR_ADDR_LSB = 24;
	localparam int HDR_COUNT_MSB = 23;
	localparam int HDR_COUNT_LSB = 0;
	localparam int HDR_COUNT_W = 24;
	localparam logic [7:0] SYS_BLOCK_ADDR = 8'h14;
	localparam logic [HDR_COUNT_W-1:0] COUNT_ALL = 24'h00_0000;

	// ==========================================================
	// sequence fields, packed back to back across the words
	localparam int SEQ_COUNT = 3;
	localparam int PHASES = 4;
	localparam int FLIPS = 2;
	localparam int FIELD_W = 9;
	localparam int SEQ_BITS = FIELD_W + PHASES + PHASES * FLIPS * FIELD_W;
	localparam int STREAM_W = WORD_W * WORD_COUNT;
	localparam int STREAM_TOP = STREAM_W - 1;

	// ==========================================================
	// reset values
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

	// ==========================================================
	// synchroniser bit positions
	localparam int PIN_LOAD = 3;
	localparam int PIN_SCLK = 2;
	localparam int PIN_SDATA = 1;
	localparam int PIN_VSYNC = 0;
	localparam int PIN_COUNT = 4;
	localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'hC;

	// ==========================================================
	// types
	typedef struct packed {
		logic [FIELD_W-1:0] repeat_length;
		logic [0:PHASES-1] start_level;
		logic [0:PHASES-1][0:FLIPS-1][FIELD_W-1:0] flip;
	} vsrb_seq_cfg_t;

	typedef struct packed {
		logic valid;
		logic [WORD_AW-1:0] addr;
		logic [WORD_W-1:0] data;
	} vsrb_word_wr_t;

	typedef struct packed {
		logic header_ok;
		logic frame_rejected;
		logic copy_busy;
		logic [IDX_W-1:0] words_taken;
	} vsrb_status_t;

	typedef enum logic [0:0] {
		VSRB_IDLE = 1'b0,
		VSRB_COPY = 1'b1
	} vsrb_copy_state_t;

endpackage

//--- design/vsrb_word_store.sv
// vertical sequence register bank: pending word store
// assumes one clock; read data appear one enabled edge after the read request
`timescale 1ns/100ps

module vsrb_word_store #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	// ==========================================================
	// storage
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] rd_data_reg;
	logic [WIDTH-1:0] rd_data_next;

	always_comb begin
		rd_data_next = rd_data_reg;
		if (rd_en) begin
			rd_data_next = mem_reg[rd_addr];
		end
	end

	// contents need no reset; every word is read during a copy, but only words marked pending are applied
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_reg <= '0;
		end else if (ce) begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data = rd_data_reg;

endmodule

//--- design/vsrb_sequence_bank.sv
// vertical sequence register bank: serial block write, pending store, sync apply
// assumes serial pins and vertical sync arrive asynchronous to REF_CLK
// What this block does
// R01: sync-type writes stay pending until first vertical sync falling edge after the write.
// R02: after reset updates are deferred until immediate mode is selected.
// R03: update select high applies writes at once, no vertical sync wait.
// R04: header bits 31..24 must hold block address 0x14; following words reach the map.
// R05: header bits 23..0 count the words; zero means all words accepted.
// R06: each sequence holds a 9-bit repetition length.
// R07: each sequence holds one start level per phase output, four phases.
// R08: each sequence holds two 9-bit flip positions per phase.
// R09: fields straddling word boundaries are rejoined from consecutive words.
// R10: unused bits, like the last word's bit 0, are ignored.
`timescale 1ns/100ps

module vsrb_sequence_bank
	import vsrb_pkg::*;
#(
	parameter int N_WORDS = WORD_COUNT
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic SER_LOAD_N,
	input wire logic SER_CLK,
	input wire logic SER_DATA,
	input wire logic VERTICAL_SYNC,
	input wire logic SYNC_UPDATE_SELECT,
	output vsrb_seq_cfg_t [SEQ_COUNT-1:0] SEQ_CFG,
	output logic [N_WORDS-1:0] PENDING_WORDS,
	output vsrb_status_t STATUS
);

	// ==========================================================
	// pin synchronisers
	logic [PIN_COUNT-1:0] sync1_reg;
	logic [PIN_COUNT-1:0] sync2_reg;
	logic sclk_prev_reg;
	logic vsync_prev_reg;
	logic load_prev_reg;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			sync1_reg <= PIN_IDLE;
			sync2_reg <= PIN_IDLE;
			sclk_prev_reg <= 1'b0;
			vsync_prev_reg <= 1'b0;
			load_prev_reg <= 1'b1;
		end else if (CLK_EN) begin
			sync1_reg <= {SER_LOAD_N, SER_CLK, SER_DATA, VERTICAL_SYNC};
			sync2_reg <= sync1_reg;
			sclk_prev_reg <= sync2_reg[PIN_SCLK];
			vsync_prev_reg <= sync2_reg[PIN_VSYNC];
			load_prev_reg <= sync2_reg[PIN_LOAD];
		end
	end

	logic sclk_rise;
	logic in_frame;
	logic vsync_fall;

	assign sclk_rise = sync2_reg[PIN_SCLK] & ~sclk_prev_reg;
	assign in_frame = ~sync2_reg[PIN_LOAD] & ~load_prev_reg;
	assign vsync_fall = vsync_prev_reg & ~sync2_reg[PIN_VSYNC];

	// ==========================================================
	// serial receiver
	function automatic logic word_accepted(
		input logic [IDX_W-1:0] idx,
		input logic hdr_ok,
		input logic [HDR_COUNT_W-1:0] count
	);
		logic ok;
		ok = hdr_ok && (idx != '0) && ({28'h000_0000, idx} <= N_WORDS);
		if (count != COUNT_ALL) begin // [R05]
			ok = ok && ({20'h0_0000, idx} <= count); // [R05]
		end
		return ok;
	endfunction

	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] shift_next;
	logic [BIT_CNT_W-1:0] bit_cnt_reg;
	logic [BIT_CNT_W-1:0] bit_cnt_next;
	logic [IDX_W-1:0] word_idx_reg;
	logic [IDX_W-1:0] word_idx_next;
	logic [HDR_COUNT_W-1:0] count_reg;
	logic [HDR_COUNT_W-1:0] count_next;
	logic hdr_ok_reg;
	logic hdr_ok_next;
	logic reject_reg;
	logic reject_next;
	logic [IDX_W-1:0] taken_reg;
	logic [IDX_W-1:0] taken_next;
	vsrb_word_wr_t wr_reg;
	vsrb_word_wr_t wr_next;

	always_comb begin
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		word_idx_next = word_idx_reg;
		count_next = count_reg;
		hdr_ok_next = hdr_ok_reg;
		reject_next = reject_reg;
		taken_next = taken_reg;
		wr_next = '0;
		if (!in_frame) begin
			// a partial word left by a short frame is dropped here
			bit_cnt_next = '0;
			word_idx_next = '0;
			hdr_ok_next = 1'b0;
		end else if (sclk_rise) begin
			shift_next = {shift_reg[WORD_W-2:0], sync2_reg[PIN_SDATA]};
			bit_cnt_next = bit_cnt_reg + 1'b1;
			if (bit_cnt_reg == LAST_BIT) begin
				if (word_idx_reg == '0) begin
					hdr_ok_next = shift_next[HDR_ADDR_MSB:HDR_ADDR_LSB] == SYS_BLOCK_ADDR; // [R04]
					reject_next = shift_next[HDR_ADDR_MSB:HDR_ADDR_LSB] != SYS_BLOCK_ADDR;
					count_next = shift_next[HDR_COUNT_MSB:HDR_COUNT_LSB]; // [R05]
					taken_next = '0;
				end else if (word_accepted(word_idx_reg, hdr_ok_reg, count_reg)) begin // [R04]
					wr_next.valid = 1'b1;
					wr_next.addr = WORD_AW'(word_idx_reg - 1'b1);
					wr_next.data = shift_next;
					taken_next = taken_reg + 1'b1;
				end
				if (word_idx_reg != IDX_SATURATE) begin
					word_idx_next = word_idx_reg + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			word_idx_reg <= '0;
			count_reg <= '0;
			hdr_ok_reg <= 1'b0;
			reject_reg <= 1'b0;
			taken_reg <= '0;
			wr_reg <= '0;
		end else if (CLK_EN) begin
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			word_idx_reg <= word_idx_next;
			count_reg <= count_next;
			hdr_ok_reg <= hdr_ok_next;
			reject_reg <= reject_next;
			taken_reg <= taken_next;
			wr_reg <= wr_next;
		end
	end

	// ==========================================================
	// pending store and apply sequencer
	vsrb_copy_state_t state_reg;
	vsrb_copy_state_t state_next;
	logic [WORD_AW-1:0] copy_idx_reg;
	logic [WORD_AW-1:0] copy_idx_next;
	logic rd_vld_reg;
	logic rd_vld_next;
	logic [WORD_AW-1:0] rd_idx_reg;
	logic [WORD_AW-1:0] rd_idx_next;
	logic [N_WORDS-1:0] dirty_reg;
	logic [N_WORDS-1:0] dirty_next;
	logic [N_WORDS-1:0] mask_reg;
	logic [N_WORDS-1:0] mask_next;
	logic [WORD_W-1:0] active_reg [N_WORDS];
	logic [WORD_W-1:0] active_next [N_WORDS];
	logic [WORD_W-1:0] rd_data;
	logic immediate;
	logic start_copy;

	// select is low after reset, so writes start out deferred
	assign immediate = SYNC_UPDATE_SELECT; // [R02] [R03]
	assign start_copy = vsync_fall && (state_reg == VSRB_IDLE); // [R01]

	vsrb_word_store #(
		.WIDTH(WORD_W),
		.DEPTH(N_WORDS),
		.AW(WORD_AW)
	) u_store (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.wr_en(wr_reg.valid),
		.wr_addr(wr_reg.addr),
		.wr_data(wr_reg.data),
		.rd_en(state_reg == VSRB_COPY),
		.rd_addr(copy_idx_reg),
		.rd_data(rd_data)
	);

	always_comb begin
		state_next = state_reg;
		copy_idx_next = copy_idx_reg;
		rd_vld_next = 1'b0;
		rd_idx_next = rd_idx_reg;
		unique case (state_reg)
			VSRB_IDLE: begin
				copy_idx_next = '0;
				if (start_copy) begin
					state_next = VSRB_COPY;
				end
			end
			VSRB_COPY: begin
				rd_vld_next = 1'b1;
				rd_idx_next = copy_idx_reg;
				copy_idx_next = copy_idx_reg + 1'b1;
				if (copy_idx_reg == WORD_AW'(N_WORDS - 1)) begin
					state_next = VSRB_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		dirty_next = dirty_reg;
		mask_next = mask_reg;
		for (int i = 0; i < N_WORDS; i++) begin
			active_next[i] = active_reg[i];
		end
		if (start_copy) begin
			// snapshot what is pending at this edge; later writes wait for the next one
			mask_next = dirty_reg; // [R01]
			dirty_next = '0;
		end
		if (rd_vld_reg && mask_reg[rd_idx_reg]) begin
			active_next[rd_idx_reg] = rd_data; // [R01]
			mask_next[rd_idx_reg] = 1'b0;
		end
		if (wr_reg.valid) begin
			if (immediate) begin
				// a newer direct write beats any older pending copy of the same word
				active_next[wr_reg.addr] = wr_reg.data; // [R03]
				dirty_next[wr_reg.addr] = 1'b0;
				mask_next[wr_reg.addr] = 1'b0;
			end else begin
				// set after the clear, so a write at the sync edge is not lost
				dirty_next[wr_reg.addr] = 1'b1; // [R01]
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_reg <= VSRB_IDLE;
			copy_idx_reg <= '0;
			rd_vld_reg <= 1'b0;
			rd_idx_reg <= '0;
			dirty_reg <= '0;
			mask_reg <= '0;
			for (int i = 0; i < N_WORDS; i++) begin
				active_reg[i] <= WORD_RESET;
			end
		end else if (CLK_EN) begin
			state_reg <= state_next;
			copy_idx_reg <= copy_idx_next;
			rd_vld_reg <= rd_vld_next;
			rd_idx_reg <= rd_idx_next;
			dirty_reg <= dirty_next;
			mask_reg <= mask_next;
			for (int i = 0; i < N_WORDS; i++) begin
				active_reg[i] <= active_next[i];
			end
		end
	end

	// ==========================================================
	// field unpacking
	// the words form one stream, first word on top; each sequence is a fixed slice
	logic [STREAM_W-1:0] stream;

	genvar gw;
	genvar gs;
	generate
		for (gw = 0; gw < WORD_COUNT; gw++) begin : g_stream
			assign stream[STREAM_TOP - WORD_W * gw -: WORD_W] = active_reg[gw]; // [R09]
		end
		for (gs = 0; gs < SEQ_COUNT; gs++) begin : g_seq
			// length, start levels, then two flips per phase, phase 1 first
			assign SEQ_CFG[gs] = stream[STREAM_TOP - SEQ_BITS * gs -: SEQ_BITS]; // [R06] [R07] [R08] [R09]
		end
	endgenerate

	// stream bit 0 lies past the last sequence and reaches no output [R10]

	// ==========================================================
	// status
	assign PENDING_WORDS = dirty_reg | mask_reg;
	assign STATUS.header_ok = hdr_ok_reg;
	assign STATUS.frame_rejected = reject_reg;
	assign STATUS.copy_busy = (state_reg == VSRB_COPY) | rd_vld_reg;
	assign STATUS.words_taken = taken_reg;

endmodule

//--- test/vsrb_asserts.sv
// checker: port relations of the sequence bank
// assumes bind onto vsrb_sequence_bank with CLK_EN held high
`timescale 1ns/100ps
module vsrb_asserts
	import vsrb_pkg::*;
#(
	parameter int N_WORDS = WORD_COUNT
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic SER_LOAD_N,
	input wire logic VERTICAL_SYNC,
	input wire logic SYNC_UPDATE_SELECT,
	input wire vsrb_seq_cfg_t [SEQ_COUNT-1:0] SEQ_CFG,
	input wire logic [N_WORDS-1:0] PENDING_WORDS,
	input wire vsrb_status_t STATUS
);
	// ==========================
	// cycles since the sync pin fell, saturating
	logic vs_last_reg;
	logic [4:0] since_fall_reg;
	logic [4:0] since_fall_next;
	always_comb begin
		since_fall_next = since_fall_reg;
		if (vs_last_reg && !VERTICAL_SYNC)
			since_fall_next = 5'h00;
		else if (since_fall_reg != 5'h1F)
			since_fall_next = since_fall_reg + 5'h01;
	end
	always_ff @(posedge REF_CLK) begin
		vs_last_reg <= VERTICAL_SYNC;
		since_fall_reg <= SYS_RST ? 5'h1F : since_fall_next;
	end
	// ==========================
	// assertions
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	chk_defer_hold: assert property ($changed(SEQ_CFG) && !SYNC_UPDATE_SELECT &&
		!$past(SYNC_UPDATE_SELECT, 3) |-> since_fall_reg < 5'h14) else $error("early apply");
	// the select acts on the edge before the flags move, so look one edge back
	chk_pend_select: assert property (|(PENDING_WORDS & ~$past(PENDING_WORDS)) |->
		!$past(SYNC_UPDATE_SELECT)) else $error("pending in immediate mode");
	chk_pend_clear: assert property (|($past(PENDING_WORDS) & ~PENDING_WORDS) |->
		since_fall_reg < 5'h14 || $past(SYNC_UPDATE_SELECT)) else $error("pending lost");
	chk_apply_all: assert property ($fell(VERTICAL_SYNC) && SER_LOAD_N &&
		!STATUS.copy_busy |-> ##16 PENDING_WORDS == '0) else $error("apply incomplete");
	chk_copy_len: assert property ($rose(STATUS.copy_busy) |-> ##[1:10]
		!STATUS.copy_busy) else $error("copy too long");
	chk_reject_quiet: assert property (STATUS.frame_rejected |->
		STATUS.words_taken == '0 && !STATUS.header_ok) else $error("reject took words");
	chk_take_ok: assert property (STATUS.words_taken > $past(STATUS.words_taken) |->
		STATUS.header_ok) else $error("word without header");
	chk_count_cap: assert property (STATUS.words_taken <= 4'h8)
		else $error("too many words");
	chk_take_step: assert property (STATUS.words_taken != $past(STATUS.words_taken) |->
		STATUS.words_taken == $past(STATUS.words_taken) + 4'h1 || STATUS.words_taken == '0)
		else $error("word count jump");
endmodule

bind vsrb_sequence_bank vsrb_asserts #(.N_WORDS(N_WORDS)) i_asserts (
	.REF_CLK(REF_CLK),
	.SYS_RST(SYS_RST),
	.SER_LOAD_N(SER_LOAD_N),
	.VERTICAL_SYNC(VERTICAL_SYNC),
	.SYNC_UPDATE_SELECT(SYNC_UPDATE_SELECT),
	.SEQ_CFG(SEQ_CFG),
	.PENDING_WORDS(PENDING_WORDS),
	.STATUS(STATUS)
);

//--- test/vsrb_host_model.sv
// host model: writes block frames on the serial port
// assumes send() is called from the bench; changes pins at falling edges
`timescale 1ns/100ps
module vsrb_host_model (
	input wire logic clk,
	output logic load_n,
	output logic sclk,
	output logic sdata
);
	initial begin
		load_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
	end
	// released data line toggles so stale bits never pass as data
	always @(negedge clk) begin
		if (load_n)
			sdata <= ~sdata;
	end
	// hp sets the high clock phase in cycles, the low phase is hp+1: 3 is the fastest allowed
	task automatic send(input logic [31:0] hdr, input logic [31:0] w[$], input int hp);
		@(negedge clk);
		load_n <= 1'b0;
		w.push_front(hdr);
		foreach (w[k]) begin
			for (int b = 31; b >= 0; b--) begin
				@(negedge clk);
				sdata <= w[k][b];
				repeat (hp) @(negedge clk);
				sclk <= 1'b1;
				repeat (hp) @(negedge clk);
				sclk <= 1'b0;
			end
		end
		repeat (4) @(negedge clk);
		load_n <= 1'b1;
	endtask
endmodule

//--- test/tb_vsrb_sequence_bank.sv
// testbench: block writes, deferred and immediate apply, refused frames
// assumes host model on the serial pins; clock enable held high
`timescale 1ns/100ps
module tb_vsrb_sequence_bank
	import vsrb_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic vsync = 1'b1;
	logic upd_sel = 1'b0;
	logic load_n;
	logic sclk;
	logic sdata;
	vsrb_seq_cfg_t [SEQ_COUNT-1:0] seq_cfg;
	logic [WORD_COUNT-1:0] pending;
	vsrb_status_t status;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] applied [1:8];
	logic [31:0] pat [$];
	logic [31:0] q2 [$];

	always #10 ref_clk = ~ref_clk;

	vsrb_sequence_bank i_dut (
		.REF_CLK(ref_clk),
		.SYS_RST(sys_rst),
		.CLK_EN(1'b1),
		.SER_LOAD_N(load_n),
		.SER_CLK(sclk),
		.SER_DATA(sdata),
		.VERTICAL_SYNC(vsync),
		.SYNC_UPDATE_SELECT(upd_sel),
		.SEQ_CFG(seq_cfg),
		.PENDING_WORDS(pending),
		.STATUS(status)
	);
	vsrb_host_model i_host (
		.clk(ref_clk),
		.load_n(load_n),
		.sclk(sclk),
		.sdata(sdata)
	);

	// ==========================
	// checking and closing
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_cfg();
		logic [255:0] s;
		s = {applied[1], applied[2], applied[3], applied[4],
			applied[5], applied[6], applied[7], applied[8]};
		for (int q = 0; q < SEQ_COUNT; q++)
			chk(256'(seq_cfg[q]), 256'(s[255-85*q -: 85]));
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// whole run is near 5000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end

	// ==========================
	// scenarios
	initial begin
		for (int i = 1; i <= 8; i++)
			applied[i] = 32'h0000_0000;
		wt(16);
		sys_rst = 1'b0;
		wt(4);
		chk(256'({pending, status}), '0);
		chk_cfg();
		// deferred full block, unused last bit written high
		for (int i = 0; i < 8; i++)
			pat.push_back(32'h9E37_79B9 * 32'(i + 3));
		pat[7][0] = 1'b1;
		i_host.send({SYS_BLOCK_ADDR, COUNT_ALL}, pat, 3);
		wt(12);
		chk(256'(pending), 256'(8'hFF));
		chk_cfg();
		vsync = 1'b0;
		wt(20);
		for (int i = 0; i < 8; i++)
			applied[i+1] = pat[i];
		chk(256'(pending), '0);
		chk_cfg();
		chk(256'(seq_cfg[0].repeat_length), 256'(pat[0][31:23]));
		chk(256'(seq_cfg[0].flip[1][0]), 256'({pat[0][0], pat[1][31:24]}));
		chk(256'(seq_cfg[2].start_level), 256'(pat[5][12:9]));
		chk(256'(seq_cfg[2].flip[3][1]), 256'(pat[7][9:1]));
		vsync = 1'b1;
		// immediate, count two, one surplus word, slow host
		upd_sel = 1'b1;
		wt(4);
		q2 = '{~pat[0], ~pat[1], ~pat[2]};
		i_host.send({SYS_BLOCK_ADDR, 24'h00_0002}, q2, 6);
		wt(12);
		applied[1] = q2[0];
		applied[2] = q2[1];
		chk(256'(status.words_taken), 256'(4'h2));
		chk(256'(pending), '0);
		chk_cfg();
		// wrong block address is refused
		q2 = '{32'hFFFF_FFFF};
		i_host.send({8'h15, 24'h00_0001}, q2, 3);
		wt(12);
		chk(256'(status.frame_rejected), 256'(1'b1));
		chk(256'(status.words_taken), '0);
		chk_cfg();
		// deferred again, count one: surplus word refused, next fall applies word 1
		upd_sel = 1'b0;
		wt(4);
		q2 = '{32'h5A5A_0F0F, 32'hFFFF_FFFF};
		i_host.send({SYS_BLOCK_ADDR, 24'h00_0001}, q2, 3);
		wt(12);
		chk(256'(status.frame_rejected), '0);
		chk(256'(status.words_taken), 256'(4'h1));
		chk(256'(pending), 256'(8'h01));
		chk_cfg();
		vsync = 1'b0;
		wt(20);
		applied[1] = q2[0];
		chk(256'(pending), '0);
		chk_cfg();
		vsync = 1'b1;
		close_out();
	end
endmodule
